// ==== data_mem_model.sv ====
`timescale 1ns/10ps
// ==========================================================================
// Banked data memory partner: 4096 bytes, combinational read in Q2
module data_mem_model (
  input  wire logic                             clk,
  input  wire logic [data_move_pkg::ADDR_W-1:0] mem_addr,
  input  wire logic                             mem_rd,
  input  wire logic                             mem_wr,
  input  wire logic [data_move_pkg::DATA_W-1:0] mem_wdata,
  output logic      [data_move_pkg::DATA_W-1:0] mem_rdata
);
  import data_move_pkg::*;

  logic [DATA_W-1:0] mem [0:4095];
  logic [DATA_W-1:0] last_reg = 8'h00;

  // ========================================================================
  // Read path
  // Outside a read the bus shows the inverse of the last byte, so a
  // design that samples late cannot pick up stale data by luck
  assign mem_rdata = mem_rd ? mem[mem_addr] : ~last_reg;

  // Write lands at the end of the strobed clock
  always @(posedge clk) begin
    if (mem_rd) last_reg <= mem[mem_addr];
    if (mem_wr) mem[mem_addr] <= mem_wdata;
  end

  // Known contents so a stray read never yields unknowns
  initial begin
    for (int i = 0; i < 4096; i++) mem[i] = 8'h00;
  end
endmodule : data_mem_model

// ==== data_move_exec.sv ====
`timescale 1ns/10ps
module data_move_exec (
  input  wire logic                              clk,
  input  wire logic                              rst_n,
  input  wire logic [data_move_pkg::WORD_W-1:0]  prog_word,
  input  wire logic                              word_valid,
  input  wire logic                              ext_set_en,
  input  wire logic [data_move_pkg::ADDR_W-1:0]  index_base,
  input  wire logic [data_move_pkg::DATA_W-1:0]  mem_rdata,
  output logic      [data_move_pkg::ADDR_W-1:0]  mem_addr,
  output logic                                   mem_rd,
  output logic                                   mem_wr,
  output logic      [data_move_pkg::DATA_W-1:0]  mem_wdata,
  output logic      [data_move_pkg::DATA_W-1:0]  acc,
  output logic      [data_move_pkg::DATA_W-1:0]  bank_sel
);
  import data_move_pkg::*;

  // ========================================================================
  // Helpers

  // Data address of a byte operand; the access bank is split in two halves
  function automatic logic [ADDR_W-1:0] bank_address(
    input logic              access_bit,
    input logic [7:0]        f,
    input logic [DATA_W-1:0] bank,
    input logic              ext,
    input logic [ADDR_W-1:0] base
  );
    logic [ADDR_W-1:0] sum;
    sum = base + {BANK_LOW_BANK, f};
    if (access_bit) begin
      bank_address = {bank[3:0], f};
    end else if (ext && (f <= INDEXED_MAX)) begin
      bank_address = sum;
    end else if (f < ACCESS_SPLIT) begin
      bank_address = {BANK_LOW_BANK, f};
    end else begin
      bank_address = {ACCESS_HIGH_BANK, f};
    end
  endfunction : bank_address

  // The accumulator lives in the file space but is held here
  function automatic logic is_acc(input logic [ADDR_W-1:0] addr);
    is_acc = (addr == ACC_FILE_ADDR);
  endfunction : is_acc

  // ========================================================================
  // Phase sequencer
  phase_if ph ();

  phase_gen u_phase (
    .clk   (clk),
    .rst_n (rst_n),
    .ph    (ph)
  );

  // ========================================================================
  // State
  logic [WORD_W-1:0] instr_reg;
  logic              instr_ok_reg;
  logic              pending_reg;
  logic [DATA_W-1:0] copy_data_reg;
  logic [DATA_W-1:0] acc_reg;
  logic [DATA_W-1:0] acc_next;
  logic [DATA_W-1:0] bank_sel_reg;
  logic [DATA_W-1:0] bank_sel_next;
  logic [ADDR_W-1:0] mem_addr_reg;
  logic [ADDR_W-1:0] mem_addr_next;
  logic              mem_rd_reg;
  logic              mem_rd_next;
  logic              mem_wr_reg;
  logic              mem_wr_next;
  logic [DATA_W-1:0] mem_wdata_reg;
  logic [DATA_W-1:0] mem_wdata_next;

  // ========================================================================
  // Decode
  wire              at_q1       = (ph.phase == Q1);
  wire              at_q2       = (ph.phase == Q2);
  wire              at_q3       = (ph.phase == Q3);
  wire              at_q4       = (ph.phase == Q4);
  wire [7:0]        lit_k       = instr_reg[7:0];
  wire [ADDR_W-1:0] file_full   = instr_reg[ADDR_W-1:0];
  wire              is_copy_src = instr_ok_reg && (instr_reg[15:12] == OP_COPY_SRC);
  wire              is_copy_dst = instr_ok_reg && pending_reg
                                  && (instr_reg[15:12] == OP_COPY_DST);
  wire              is_bank     = instr_ok_reg && (instr_reg[15:8] == OP_BANK_LOAD);
  wire              is_lit      = instr_ok_reg && (instr_reg[15:8] == OP_LIT_LOAD);
  wire              is_store    = instr_ok_reg && (instr_reg[15:9] == OP_STORE);
  wire [ADDR_W-1:0] store_addr  = bank_address(instr_reg[8], lit_k, bank_sel_reg,
                                               ext_set_en, index_base);
  wire              src_is_acc  = is_acc(file_full);
  wire              dst_is_acc  = is_acc(file_full);
  wire              store_acc   = is_acc(store_addr);

  // Memory strobes: read stands in Q2, write stands in Q4
  assign mem_rd_next = at_q1 && ((is_copy_src && !src_is_acc)
                                 || (is_store && !store_acc));
  assign mem_wr_next = at_q3 && ((is_copy_dst && !dst_is_acc)
                                 || (is_store && !store_acc));
  assign mem_addr_next = mem_rd_next ? (is_copy_src ? file_full : store_addr) :
                         mem_wr_next ? (is_copy_dst ? file_full : store_addr) :
                         mem_addr_reg;
  assign mem_wdata_next = !mem_wr_next ? mem_wdata_reg :
                          is_copy_dst  ? copy_data_reg : acc_reg;

  // Accumulator and bank select change only at the end of Q4
  assign acc_next = !at_q4                     ? acc_reg :
                    is_lit                     ? lit_k :
                    (is_copy_dst && dst_is_acc) ? copy_data_reg :
                    acc_reg;
  assign bank_sel_next = (at_q4 && is_bank) ? {BANK_UPPER_ZERO, lit_k[3:0]}
                                            : bank_sel_reg;

  // ========================================================================
  // Instruction latch; a missing word leaves a no-op cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      instr_reg    <= WORD_RESET;
      instr_ok_reg <= 1'h0;
    end else if (at_q4) begin
      instr_reg    <= word_valid ? prog_word : instr_reg;
      instr_ok_reg <= word_valid;
    end
  end

  // Copy pending across the gap; a stalled second word stretches it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pending_reg <= 1'h0;
    end else if (at_q2 && is_copy_src) begin
      pending_reg <= 1'h1;
    end else if (at_q4 && instr_ok_reg && !is_copy_src) begin
      pending_reg <= 1'h0;
    end
  end

  // Source byte captured at the end of the read phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      copy_data_reg <= ACC_RESET;
    end else if (at_q2 && is_copy_src) begin
      copy_data_reg <= src_is_acc ? acc_reg : mem_rdata;
    end
  end

  // Output and working registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg       <= ACC_RESET;
      bank_sel_reg  <= BANK_RESET;
      mem_addr_reg  <= ADDR_RESET;
      mem_rd_reg    <= 1'h0;
      mem_wr_reg    <= 1'h0;
      mem_wdata_reg <= ACC_RESET;
    end else begin
      acc_reg       <= acc_next;
      bank_sel_reg  <= bank_sel_next;
      mem_addr_reg  <= mem_addr_next;
      mem_rd_reg    <= mem_rd_next;
      mem_wr_reg    <= mem_wr_next;
      mem_wdata_reg <= mem_wdata_next;
    end
  end

  assign mem_addr  = mem_addr_reg;
  assign mem_rd    = mem_rd_reg;
  assign mem_wr    = mem_wr_reg;
  assign mem_wdata = mem_wdata_reg;
  assign acc       = acc_reg;
  assign bank_sel  = bank_sel_reg;

  // ========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_bank_upper;
    bank_sel[7:4] == BANK_UPPER_ZERO;
  endproperty
  a_bank_upper: assert property (p_bank_upper) else $error("bank upper bits set");

  property p_bank_load;
    at_q4 && is_bank |=> bank_sel == {BANK_UPPER_ZERO, $past(lit_k[3:0])};
  endproperty
  a_bank_load: assert property (p_bank_load) else $error("bank load wrong");

  property p_lit_load;
    at_q4 && is_lit |=> acc == $past(lit_k);
  endproperty
  a_lit_load: assert property (p_lit_load) else $error("literal load wrong");

  property p_store_write;
    at_q3 && is_store && !store_acc |=> mem_wr && mem_wdata == $past(acc)
                                        && ph.phase == Q4 ##1 !mem_wr;
  endproperty
  a_store_write: assert property (p_store_write) else $error("store write wrong");

  property p_store_banked;
    at_q3 && is_store && instr_reg[8] && !store_acc
      |=> mem_addr == {$past(bank_sel[3:0]), $past(lit_k)};
  endproperty
  a_store_banked: assert property (p_store_banked) else $error("banked address wrong");

  property p_store_indexed;
    at_q3 && is_store && !instr_reg[8] && ext_set_en && lit_k <= INDEXED_MAX
      && !store_acc |=> mem_addr == $past(index_base) + {BANK_LOW_BANK, $past(lit_k)};
  endproperty
  a_store_indexed: assert property (p_store_indexed) else $error("indexed address wrong");

  property p_copy_read;
    at_q1 && is_copy_src && !src_is_acc |=> mem_rd && mem_addr == $past(file_full)
                                            ##1 !mem_rd;
  endproperty
  a_copy_read: assert property (p_copy_read) else $error("copy read wrong");

  property p_copy_write;
    at_q3 && is_copy_dst && !dst_is_acc |=> mem_wr && mem_wdata == $past(copy_data_reg)
                                            && mem_addr == $past(file_full);
  endproperty
  a_copy_write: assert property (p_copy_write) else $error("copy write wrong");

  property p_copy_to_acc;
    at_q4 && is_copy_dst && dst_is_acc |=> acc == $past(copy_data_reg);
  endproperty
  a_copy_to_acc: assert property (p_copy_to_acc) else $error("copy into acc wrong");

  property p_wr_only_q4;
    mem_wr |-> ph.phase == Q4 && !mem_rd;
  endproperty
  a_wr_only_q4: assert property (p_wr_only_q4) else $error("write outside Q4");

  property p_pending_clears;
    at_q4 && is_copy_dst |=> !pending_reg;
  endproperty
  a_pending_clears: assert property (p_pending_clears) else $error("copy not finished");

  c_copy:  cover property (at_q3 && is_copy_dst ##1 mem_wr);
  c_store: cover property (at_q3 && is_store ##1 mem_wr);
  c_bank:  cover property (at_q4 && is_bank);
  c_stall: cover property (pending_reg && at_q4 && !word_valid);

endmodule : data_move_exec

// ==== data_move_pkg.sv ====
// ==========================================================================
// Shared constants and types for the data-move execution block
package data_move_pkg;

  // ========================================================================
  // Widths
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int WORD_W = 16;

  // ========================================================================
  // Opcode prefixes
  localparam logic [3:0] OP_COPY_SRC  = 4'hC;   // First word of the copy
  localparam logic [3:0] OP_COPY_DST  = 4'hF;   // Second word of the copy
  localparam logic [7:0] OP_BANK_LOAD = 8'h01;
  localparam logic [7:0] OP_LIT_LOAD  = 8'h0E;
  localparam logic [6:0] OP_STORE     = 7'h37;  // 0110 111, access bit follows

  // ========================================================================
  // Data space layout
  localparam logic [ADDR_W-1:0] ACC_FILE_ADDR    = 12'hFE8; // Accumulator's file address
  localparam logic [7:0]        ACCESS_SPLIT     = 8'h80;   // Low access half ends here
  localparam logic [7:0]        INDEXED_MAX      = 8'h5F;   // Highest indexed offset
  localparam logic [3:0]        ACCESS_HIGH_BANK = 4'hF;
  localparam logic [3:0]        BANK_LOW_BANK    = 4'h0;
  localparam logic [3:0]        BANK_UPPER_ZERO  = 4'h0;

  // ========================================================================
  // Reset values
  localparam logic [DATA_W-1:0] ACC_RESET  = 8'h00;
  localparam logic [DATA_W-1:0] BANK_RESET = 8'h00;
  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 12'h000;

  // ========================================================================
  // Quarter-cycle phases of one instruction cycle
  typedef enum logic [1:0] {Q1, Q2, Q3, Q4} phase_type;

endpackage : data_move_pkg

// ==== phase_gen.sv ====
`timescale 1ns/10ps
// ==========================================================================
// Four-phase sequencer, one phase per clock
module phase_gen (
  input  wire logic clk,
  input  wire logic rst_n,
  phase_if.gen      ph
);
  import data_move_pkg::*;

  phase_type phase_reg;
  phase_type phase_next;

  // Phases wrap Q4 back to Q1
  always_comb begin
    case (phase_reg)
      Q1:      phase_next = Q2;
      Q2:      phase_next = Q3;
      Q3:      phase_next = Q4;
      Q4:      phase_next = Q1;
      default: phase_next = Q1;
    endcase
  end

  // Phase register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= Q1;
    end else begin
      phase_reg <= phase_next;
    end
  end

  assign ph.phase = phase_reg;

endmodule : phase_gen

// ==== phase_if.sv ====
`timescale 1ns/10ps
// ==========================================================================
// Quarter-phase bundle from the phase generator to the execution logic
interface phase_if;
  import data_move_pkg::*;

  phase_type phase;

  modport gen (output phase);
  modport use_side (input phase);

endinterface : phase_if

// ==== test_data_move_instruction_exec.sv ====
`timescale 1ns/10ps
// ==========================================================================
// Self-checking bench for the data-move execution block
module test_data_move_instruction_exec;
  import data_move_pkg::*;

  logic              clk        = 1'b0;
  logic              rst_n      = 1'b0;
  logic [WORD_W-1:0] prog_word  = WORD_RESET;
  logic              word_valid = 1'b0;
  logic              ext_set_en = 1'b0;
  logic [ADDR_W-1:0] index_base = ADDR_RESET;
  logic [DATA_W-1:0] mem_rdata;
  logic [ADDR_W-1:0] mem_addr;
  logic              mem_rd;
  logic              mem_wr;
  logic [DATA_W-1:0] mem_wdata;
  logic [DATA_W-1:0] acc;
  logic [DATA_W-1:0] bank_sel;
  int                n_errors   = 0;
  int                checks     = 0;
  int                cyc        = 0;
  int                n_rd       = 0;
  int                n_wr       = 0;

  always #20 clk = ~clk;

  data_move_exec data_move_exec_i (.clk(clk), .rst_n(rst_n), .prog_word(prog_word),
    .word_valid(word_valid), .ext_set_en(ext_set_en), .index_base(index_base),
    .mem_rdata(mem_rdata), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .acc(acc), .bank_sel(bank_sel));

  data_mem_model data_mem_model_i (.clk(clk), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  // ========================================================================
  // Common tasks
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  // One instruction cycle; the word is taken at the fourth edge
  task automatic issue(input logic [15:0] w, input logic v);
    prog_word  <= w;
    word_valid <= v;
    repeat (4) @(posedge clk);
  endtask : issue

  task automatic nop();
    issue(16'h0000, 1'b0);
  endtask : nop

  // Two idle cycles: results land on the edge where one idle cycle ends,
  // so looking there would race the design's own update
  task automatic settle();
    nop();
    nop();
  endtask : settle

  task automatic copy(input logic [11:0] s, input logic [11:0] d);
    issue({OP_COPY_SRC, s}, 1'b1);
    issue({OP_COPY_DST, d}, 1'b1);
  endtask : copy

  // ========================================================================
  // Strobe monitor: edge n after release is cyc+1, a cycle spans 4 edges
  always @(posedge clk) begin
    if (!rst_n) cyc <= 0;
    else cyc <= cyc + 1;
    if (rst_n && mem_rd) begin
      n_rd++;
      chk("read_phase", 16'(cyc % 4), 16'h0001);
    end
    if (rst_n && mem_wr) begin
      n_wr++;
      chk("write_phase", 16'(cyc % 4), 16'h0003);
    end
  end

  // ========================================================================
  // Scenarios
  task automatic t_reset();
    chk("acc", 16'(acc), 16'h0000);
    chk("bank_sel", 16'(bank_sel), 16'h0000);
    chk("strobes", {14'h0000, mem_rd, mem_wr}, 16'h0000);
    $display("done reset");
  endtask : t_reset

  task automatic t_literal();
    logic [7:0] k [3] = '{8'h00, 8'h5A, 8'hFF};
    foreach (k[i]) begin
      issue({OP_LIT_LOAD, 8'h11}, 1'b1);
      issue({OP_LIT_LOAD, k[i]}, 1'b1);
      settle();
      chk("acc", 16'(acc), 16'(k[i]));
    end
    $display("done literal");
  endtask : t_literal

  task automatic t_bank();
    logic [7:0] k [3] = '{8'hF5, 8'h3A, 8'h0F};
    foreach (k[i]) begin
      issue({OP_BANK_LOAD, k[i]}, 1'b1);
      settle();
      chk("bank_sel", 16'(bank_sel), {12'h000, k[i][3:0]});
    end
    $display("done bank");
  endtask : t_bank

  // Access bit, offset, extended mode, bank and expected address per row
  task automatic t_store();
    logic        a [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
    logic [7:0]  f [6] = '{8'h23, 8'hFF, 8'h10, 8'hA0, 8'h5F, 8'h60};
    logic        x [6] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    logic [7:0]  b [6] = '{8'h05, 8'h0F, 8'h03, 8'h03, 8'h03, 8'h03};
    logic [11:0] e [6] = '{12'h523, 12'hFFF, 12'h010, 12'hFA0, 12'h04F, 12'h060};
    int w0;
    foreach (a[i]) begin
      ext_set_en <= x[i];
      index_base <= 12'hFF0;
      issue({OP_BANK_LOAD, b[i]}, 1'b1);
      issue({OP_LIT_LOAD, 8'h40 + 8'(i)}, 1'b1);
      w0 = n_wr;
      issue({OP_STORE, a[i], f[i]}, 1'b1);
      settle();
      chk("stored", 16'(data_mem_model_i.mem[e[i]]), 16'h0040 + 16'(i));
      chk("store_writes", 16'(n_wr - w0), 16'h0001);
    end
    ext_set_en <= 1'b0;
    $display("done store");
  endtask : t_store

  // Destinations stay clear of program counter low and stack top bytes
  task automatic t_copy();
    int r0;
    int w0;
    data_mem_model_i.mem[12'hFFF] = 8'h33;
    r0 = n_rd;
    w0 = n_wr;
    copy(12'hFFF, 12'h000);
    settle();
    chk("copy_dst", 16'(data_mem_model_i.mem[12'h000]), 16'h0033);
    chk("copy_rw", 16'((n_rd - r0) * 16 + (n_wr - w0)), 16'h0011);
    data_mem_model_i.mem[12'h234] = 8'h5C;
    issue({OP_COPY_SRC, 12'h234}, 1'b1);
    nop();
    issue({OP_COPY_DST, 12'h789}, 1'b1);
    settle();
    chk("stalled_copy", 16'(data_mem_model_i.mem[12'h789]), 16'h005C);
    issue({OP_LIT_LOAD, 8'h77}, 1'b1);
    r0 = n_rd;
    copy(ACC_FILE_ADDR, 12'h456);
    settle();
    chk("acc_src", 16'(data_mem_model_i.mem[12'h456]), 16'h0077);
    chk("acc_src_reads", 16'(n_rd - r0), 16'h0000);
    data_mem_model_i.mem[12'h200] = 8'h9C;
    w0 = n_wr;
    copy(12'h200, ACC_FILE_ADDR);
    settle();
    chk("acc_dst", 16'(acc), 16'h009C);
    chk("acc_dst_writes", 16'(n_wr - w0), 16'h0000);
    $display("done copy");
  endtask : t_copy

  // ========================================================================
  // Main sequence and watchdog
  initial begin
    repeat (16) @(posedge clk);
    t_reset();
    rst_n <= 1'b1;
    t_literal();
    t_bank();
    t_store();
    t_copy();
    test_done();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    test_done();
  end
endmodule : test_data_move_instruction_exec
